// ### adc_ready_pkg.sv
// Shared constants and types for the conversion-timing and ready-chain block
package adc_ready_pkg;
  // Channel count, word widths and longest chain
  localparam int NUM_CH = 4;
  localparam int WIDE_BITS = 24;
  localparam int NARROW_BITS = 16;
  localparam int MAX_CHAIN = 8;
  // Modulator clock divide from the oscillator input
  localparam int MOD_DIV = 8;
  localparam logic [2:0] MOD_DIV_LAST = 3'h7;
  // Result FIFO shape
  localparam int FIFO_DEPTH = 8;
  localparam int FIFO_WIDTH = 2 + WIDE_BITS;
  // Reset values of programmed settings
  localparam logic [15:0] RATE_RESET = 16'h00bf;
  localparam logic [7:0] DELAY_RESET = 8'h00;
  // Ready sequencer states
  typedef enum logic [1:0] {
    RDY_IDLE = 2'b00,
    RDY_SHOW = 2'b01,
    RDY_DONE = 2'b10
  } rdy_state_t;
endpackage : adc_ready_pkg

// ### result_stream_if.sv
// Valid/ready stream carrying channel-tagged results between modules
`timescale 1ns/1ps
interface result_stream_if #(parameter int W = 26);
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport source (output valid, output data, input ready);
  modport sink (input valid, input data, output ready);
endinterface : result_stream_if

// ### result_fifo.sv
// Small register-file FIFO with registered read data
`timescale 1ns/1ps
module result_fifo #(
  parameter int WIDTH = 26,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Fill and drain sides
  result_stream_if.sink wr,
  result_stream_if.source rd
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];  // Storage
  logic [AW-1:0] wrPtr;           // Next slot to fill
  logic [AW-1:0] rdPtr;           // Next slot to drain
  logic [AW:0] count;             // Occupancy
  logic [WIDTH-1:0] outData;      // Registered head word
  logic outValid;                 // Head word present
  logic push;
  logic pop;
  logic load;

  // Honest full: refuse writes once every slot is taken
  assign wr.ready = (count != AW'(0) + (AW+1)'(DEPTH));
  assign push = wr.valid && wr.ready;
  // Refill the output register when empty or being drained
  assign load = (count != '0) && (!outValid || rd.ready);
  assign pop = load;
  assign rd.valid = outValid;
  assign rd.data = outData;

  // Storage write
  always_ff @(posedge mclk) begin
    if (push) begin
      mem[wrPtr] <= wr.data;
    end
  end

  // Pointers and occupancy
  always_ff @(posedge mclk) begin
    if (rst) begin
      wrPtr <= '0;
      rdPtr <= '0;
      count <= '0;
    end else begin
      if (push) wrPtr <= wrPtr + AW'(1);
      if (pop) rdPtr <= rdPtr + AW'(1);
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  // Output register; read data always come from a flop
  always_ff @(posedge mclk) begin
    if (rst) begin
      outValid <= 1'b0;
      outData <= '0;
    end else if (load) begin
      outValid <= 1'b1;
      outData <= mem[rdPtr];
    end else if (rd.ready) begin
      outValid <= 1'b0;
    end
  end
endmodule : result_fifo

// ### adc_ready_chain_sync.sv
// Conversion timing, ready chaining and sample alignment for a four-channel converter
// Operation
// [RL1] Ready low on new result when upstream low
// [RL2] Chip-select falling edge returns ready high
// [RL3] Upstream ready high forces ready high
// [RL4] Sync falling edge realigns sampling timing
// [RL5] Chained devices look like one converter
// [RL6] Modulator stream at oscillator rate over eight
// [RL7] Each channel has own sampling delay
// [RL8] Output data rate set by software
// [RL9] Results are 24-bit or 16-bit words
// [RL10] Modulator clock is oscillator divided by eight
// [RL11] Grant plus chip-select enables serial transfer
// [RL12] Ready stays high after reset until result
`timescale 1ns/1ps
module adc_ready_chain_sync #(
  parameter bit WIDE_VARIANT = 1'b1
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Oscillator input, sampled in the mclk domain
  input wire logic osc_clock_in,
  // Chain and alignment pins
  input wire logic ready_chain_in_n,
  input wire logic sync_in,
  input wire logic chain_grant_in,
  input wire logic chip_select_n,
  // Settings from the configuration path
  input wire logic [15:0] rateSetting,
  input wire logic [31:0] chDelay,
  // Modulator sample values per channel
  input wire logic [adc_ready_pkg::NUM_CH-1:0] modBit,
  // Result drain towards the serial shifter
  input wire logic resultTake,
  output logic resultValid,
  output logic [adc_ready_pkg::FIFO_WIDTH-1:0] resultWord,
  // Pins
  output logic ready_out_n,
  output logic modClock,
  output logic transferEnable,
  output logic sampleStrobe
);
  localparam int NC = adc_ready_pkg::NUM_CH;
  localparam int WB = adc_ready_pkg::WIDE_BITS;

  result_stream_if #(.W(adc_ready_pkg::FIFO_WIDTH)) fill();
  result_stream_if #(.W(adc_ready_pkg::FIFO_WIDTH)) drain();

  logic oscPrev;              // Previous oscillator level
  logic [2:0] divCount;       // Oscillator edges into modulator period
  logic modTick;              // One per modulator sample
  logic syncPrev;             // Previous sync level
  logic syncFall;             // Alignment request
  logic csPrev;               // Previous chip-select level
  logic csFall;               // Chip-select falling edge
  logic [15:0] rateCount;     // Modulator ticks into output period
  logic frameTick;            // Start of an output period
  logic [7:0] delayCount [NC];// Per-channel delay down-counters
  logic [NC-1:0] delayArmed;  // Channel waiting to sample
  logic [WB-1:0] accum [NC];  // Bit-stream accumulators
  logic [NC-1:0] chReady;     // Channel holds a finished result
  logic [1:0] emitCh;         // Next channel pushed into FIFO
  logic newResult;            // Whole frame queued
  adc_ready_pkg::rdy_state_t rdyState;

  // Edge detect on the oscillator; inputs are synchronous to mclk
  // Oscillator history runs through reset, so no false rise follows release
  always_ff @(posedge mclk) begin
    oscPrev <= osc_clock_in;
    if (rst) begin
      syncPrev <= 1'b0;
      csPrev <= 1'b1;
    end else begin
      syncPrev <= sync_in;
      csPrev <= chip_select_n;
    end
  end
  assign syncFall = syncPrev && !sync_in;
  assign csFall = csPrev && !chip_select_n;

  // Divide oscillator rising edges by eight for the modulator
  always_ff @(posedge mclk) begin
    if (rst || syncFall) begin
      divCount <= '0;
      modClock <= 1'b0;
    end else if (osc_clock_in && !oscPrev) begin
      divCount <= divCount + 3'h1; // see [RL10]
      modClock <= (divCount >= 3'h3) && (divCount != adc_ready_pkg::MOD_DIV_LAST);
    end
  end
  // One modulator sample per eight oscillator edges, 3.072 Msps at 24.576 MHz
  assign modTick = osc_clock_in && !oscPrev && (divCount == adc_ready_pkg::MOD_DIV_LAST); // see [RL6]

  // Output-rate counter; sync restarts the period so chained parts line up
  always_ff @(posedge mclk) begin
    if (rst || syncFall) begin // see [RL4]
      rateCount <= '0;
    end else if (modTick) begin
      if (rateCount >= rateSetting) rateCount <= '0; // see [RL8]
      else rateCount <= rateCount + 16'h0001;
    end
  end
  assign frameTick = modTick && (rateCount >= rateSetting);

  // Per-channel delay and accumulation, one generate slice per channel
  for (genvar c = 0; c < NC; c++) begin : gCh
    always_ff @(posedge mclk) begin
      if (rst || syncFall) begin
        delayArmed[c] <= 1'b0;
        delayCount[c] <= adc_ready_pkg::DELAY_RESET;
        accum[c] <= '0;
        chReady[c] <= 1'b0;
      end else begin
        // Clear on push first, so a new result set in the same cycle wins
        if (fill.valid && fill.ready && emitCh == 2'(c)) chReady[c] <= 1'b0;
        if (frameTick) begin
          // Independent delay before this channel's sample is taken
          delayArmed[c] <= 1'b1;
          delayCount[c] <= chDelay[c*8 +: 8]; // see [RL7]
        end else if (delayArmed[c] && modTick) begin
          if (delayCount[c] == 8'h00) begin
            delayArmed[c] <= 1'b0;
            chReady[c] <= 1'b1;
          end else begin
            delayCount[c] <= delayCount[c] - 8'h01;
          end
        end
        // Crude decimation: count ones of the bit stream
        if (modTick && !(delayArmed[c] && delayCount[c] == 8'h00)) begin
          accum[c] <= accum[c] + WB'(modBit[c]);
        end else if (modTick) begin
          accum[c] <= '0;
        end
      end
    end
  end

  // Queue finished channels in order; FIFO back-pressure stalls this
  assign fill.valid = chReady[emitCh];
  // Narrow variant keeps the upper sixteen bits, low bits zero
  assign fill.data = {emitCh, WIDE_VARIANT ? accum[emitCh] :
    {accum[emitCh][WB-1 -: adc_ready_pkg::NARROW_BITS], 8'h00}}; // see [RL9]
  always_ff @(posedge mclk) begin
    if (rst || syncFall) begin
      emitCh <= '0;
    end else if (fill.valid && fill.ready) begin
      emitCh <= emitCh + 2'h1;
    end
  end
  assign newResult = fill.valid && fill.ready && (emitCh == 2'(NC-1));

  result_fifo #(
    .WIDTH(adc_ready_pkg::FIFO_WIDTH),
    .DEPTH(adc_ready_pkg::FIFO_DEPTH)
  ) uFifo (
    .mclk(mclk),
    .rst(rst),
    .wr(fill),
    .rd(drain)
  );
  assign drain.ready = resultTake && transferEnable;

  // Drain outputs registered
  always_ff @(posedge mclk) begin
    if (rst) begin
      resultValid <= 1'b0;
      resultWord <= '0;
    end else begin
      // Valid only for a word actually taken this cycle, never for a parked head
      resultValid <= drain.valid && drain.ready;
      resultWord <= drain.data;
    end
  end

  // Ready sequencer; the chain input gates the pin, so a chain reads as one part
  always_ff @(posedge mclk) begin
    if (rst) begin
      rdyState <= adc_ready_pkg::RDY_IDLE; // see [RL12]
      ready_out_n <= 1'b1;
    end else begin
      unique case (rdyState)
        adc_ready_pkg::RDY_IDLE: begin
          if (newResult) rdyState <= adc_ready_pkg::RDY_SHOW;
        end
        adc_ready_pkg::RDY_SHOW: begin
          if (csFall) rdyState <= adc_ready_pkg::RDY_DONE; // see [RL2]
        end
        adc_ready_pkg::RDY_DONE: begin
          if (newResult) rdyState <= adc_ready_pkg::RDY_SHOW;
        end
        default: rdyState <= adc_ready_pkg::RDY_IDLE;
      endcase
      // Upstream high wins; else show a pending result
      if (ready_chain_in_n) ready_out_n <= 1'b1; // see [RL3] [RL5]
      else if (csFall) ready_out_n <= 1'b1; // see [RL2]
      else ready_out_n <= !(newResult || rdyState == adc_ready_pkg::RDY_SHOW); // see [RL1]
    end
  end

  // Transfer window opens on chip-select fall with grant low, shuts when deselected
  always_ff @(posedge mclk) begin
    if (rst) begin
      transferEnable <= 1'b0;
    end else if (chip_select_n) begin
      transferEnable <= 1'b0; // see [RL11]
    end else if (csFall && !chain_grant_in) begin
      transferEnable <= 1'b1; // see [RL11]
    end
  end

  // Pulse marking each aligned output period
  always_ff @(posedge mclk) begin
    if (rst) sampleStrobe <= 1'b0;
    else sampleStrobe <= frameTick;
  end
endmodule : adc_ready_chain_sync

// ### adc_ready_chain_sync_chk.sv
// Checker for ready chaining, transfer enable and timing outputs
`timescale 1ns/1ps
module adc_ready_chain_sync_chk (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Watched pins
  input wire logic osc_clock_in,
  input wire logic ready_chain_in_n,
  input wire logic sync_in,
  input wire logic chain_grant_in,
  input wire logic chip_select_n,
  input wire logic resultTake,
  input wire logic resultValid,
  input wire logic ready_out_n,
  input wire logic modClock,
  input wire logic transferEnable,
  input wire logic sampleStrobe
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  logic oscPrev; // Last oscillator sample
  logic [3:0] oscCnt; // Oscillator rises since last modClock edge
  logic [1:0] armed; // Skip partial windows after reset or sync
  logic oscRise;
  assign oscRise = osc_clock_in && !oscPrev;
  // Count oscillator rises per modClock half period
  always_ff @(posedge mclk) begin
    oscPrev <= osc_clock_in;
    if (rst || $fell(sync_in)) begin
      oscCnt <= 4'h0;
      armed <= 2'h0;
    end else if ($changed(modClock)) begin
      oscCnt <= 4'h0;
      armed <= armed + {1'b0, armed != 2'h3};
    end else begin
      oscCnt <= oscCnt + {3'h0, oscRise};
    end
  end
  rst_ready_a: assert property ($past(rst) |-> ready_out_n)
    else $error("ready low after reset");
  up_high_a: assert property (ready_chain_in_n |=> ready_out_n)
    else $error("ready low with upstream high");
  cs_fall_a: assert property ($fell(chip_select_n) |=> ready_out_n)
    else $error("ready low after select fall");
  ready_cause_a: assert property ($fell(ready_out_n) |-> !$past(ready_chain_in_n))
    else $error("ready fell with upstream high");
  ready_hold_a: assert property (!ready_out_n && !ready_chain_in_n && chip_select_n
    |=> !ready_out_n)
    else $error("ready dropped early");
  mod_div_a: assert property ($changed(modClock) && armed == 2'h3 |->
    oscCnt + {3'h0, oscRise} == 4'h4)
    else $error("modulator half period wrong");
  strobe_pulse_a: assert property (sampleStrobe |=> !sampleStrobe)
    else $error("strobe too long");
  te_off_a: assert property (chip_select_n |=> !transferEnable)
    else $error("transfer on while deselected");
  te_on_a: assert property ($rose(transferEnable) |->
    !$past(chain_grant_in) && !$past(chip_select_n))
    else $error("transfer on without grant");
  take_gate_a: assert property (resultValid |-> $past(resultTake) && $past(transferEnable))
    else $error("word without take");
  cover property ($fell(ready_out_n));
  cover property ($rose(transferEnable));
  cover property ($fell(sync_in));
endmodule : adc_ready_chain_sync_chk
bind adc_ready_chain_sync adc_ready_chain_sync_chk u_adc_ready_chain_sync_chk (.mclk(mclk),
  .rst(rst), .osc_clock_in(osc_clock_in), .ready_chain_in_n(ready_chain_in_n),
  .sync_in(sync_in), .chain_grant_in(chain_grant_in), .chip_select_n(chip_select_n),
  .resultTake(resultTake), .resultValid(resultValid), .ready_out_n(ready_out_n),
  .modClock(modClock), .transferEnable(transferEnable), .sampleStrobe(sampleStrobe));

// ### host_model.sv
// Host side: selects the chain, drains one frame of four words
`timescale 1ns/1ps
module host_model (
  // Clock and command
  input wire logic mclk,
  input wire logic go,
  input wire logic slow,
  // Device side
  input wire logic transferEnable,
  input wire logic resultValid,
  input wire logic [25:0] resultWord,
  output logic chip_select_n,
  output logic chain_grant_in,
  output logic resultTake,
  output logic [7:0] tags,
  output logic done
);
  int n;
  int k;
  // One transfer per go; takes are counted so no fifth word is popped and lost
  initial begin
    chip_select_n = 1'b1;
    chain_grant_in = 1'b1;
    resultTake = 1'b0;
    done = 1'b0;
    tags = 8'h00;
    forever begin
      @(posedge mclk iff go);
      @(negedge mclk);
      chain_grant_in = 1'b0;
      chip_select_n = 1'b0;
      do @(posedge mclk); while (transferEnable !== 1'b1);
      repeat (slow ? 20 : 1) @(negedge mclk);
      n = 0;
      k = 0;
      resultTake = 1'b1;
      while (n < 4) begin
        @(posedge mclk);
        if (resultValid === 1'b1) begin
          tags[2*n +: 2] = resultWord[25:24];
          n++;
        end
        if (resultTake) k++;
        @(negedge mclk);
        if (k == 4) resultTake = 1'b0;
      end
      chip_select_n = 1'b1;
      chain_grant_in = 1'b1;
      done = 1'b1;
      @(posedge mclk iff !go);
      done = 1'b0;
    end
  end
endmodule : host_model

// ### test_adc_ready_chain_sync.sv
// Self-checking bench for the ready chain block
`timescale 1ns/1ps
module test_adc_ready_chain_sync;
  logic mclk, rst, osc_clock_in, ready_chain_in_n, sync_in, chain_grant_in, chip_select_n;
  logic resultTake, resultValid, ready_out_n, modClock, transferEnable, sampleStrobe;
  logic go, slow, done;
  logic [15:0] rateSetting;
  logic [31:0] chDelay;
  logic [25:0] resultWord;
  logic [7:0] tags;
  int failCount = 0;
  int cmpCount = 0;
  int n;
  adc_ready_chain_sync u_adc_ready_chain_sync (.mclk(mclk), .rst(rst),
    .osc_clock_in(osc_clock_in), .ready_chain_in_n(ready_chain_in_n), .sync_in(sync_in),
    .chain_grant_in(chain_grant_in), .chip_select_n(chip_select_n),
    .rateSetting(rateSetting), .chDelay(chDelay), .modBit(4'h5), .resultTake(resultTake),
    .resultValid(resultValid), .resultWord(resultWord), .ready_out_n(ready_out_n),
    .modClock(modClock), .transferEnable(transferEnable), .sampleStrobe(sampleStrobe));
  host_model u_host_model (.mclk(mclk), .go(go), .slow(slow),
    .transferEnable(transferEnable), .resultValid(resultValid), .resultWord(resultWord),
    .chip_select_n(chip_select_n), .chain_grant_in(chain_grant_in),
    .resultTake(resultTake), .tags(tags), .done(done));
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // Oscillator at half the system rate, so one modulator tick is 16 cycles
  always @(negedge mclk) osc_clock_in <= ~osc_clock_in;
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmpCount++;
    if (seen !== exp) begin
      failCount++;
      $display("wrong value %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check
  task automatic wait_ready(output int c);
    c = 0;
    do begin @(posedge mclk); #1; c++; end while (ready_out_n !== 1'b0 && c < 500);
  endtask : wait_ready
  task automatic wait_strobe(output int c);
    c = 0;
    do begin @(posedge mclk); #1; c++; end while (sampleStrobe !== 1'b1 && c < 500);
  endtask : wait_strobe
  // Drain one frame; channels must come out 0..3
  task automatic drain(input logic isSlow);
    int c;
    @(negedge mclk);
    slow = isSlow;
    go = 1'b1;
    c = 0;
    do begin @(negedge mclk); c++; end while (done !== 1'b1 && c < 300);
    check("channel order", {24'h0, tags}, 32'he4);
    go = 1'b0;
    @(negedge mclk);
  endtask : drain
  // Equal delay on all channels shifts ready by exactly two ticks
  task automatic t_delay;
    int s, l0, l1;
    wait_strobe(s);
    wait_ready(l0);
    drain(1'b1);
    chDelay = 32'h02020202;
    wait_strobe(s);
    wait_ready(l1);
    drain(1'b0);
    check("delay shift", l1, l0 + 32);
  endtask : t_delay
  // Strobe distance from a sync fall is the same for two falls at one oscillator phase
  task automatic t_sync;
    int a, b;
    @(negedge mclk);
    sync_in = 1'b1;
    // Both falls land as the oscillator drops, so the two phases match
    repeat (7) @(negedge mclk iff osc_clock_in);
    sync_in = 1'b0;
    wait_strobe(a);
    repeat (45) @(negedge mclk);
    sync_in = 1'b1;
    @(negedge mclk iff osc_clock_in);
    sync_in = 1'b0;
    wait_strobe(b);
    check("strobe after sync", b, a);
    check("strobe found", a < 300, 1'b1);
  endtask : t_sync
  // Rate changed just after a strobe, so the counter never overshoots
  task automatic t_rate(input logic [15:0] r);
    int c;
    wait_strobe(c);
    @(negedge mclk);
    rateSetting = r;
    wait_strobe(c);
    wait_strobe(c);
    check("frame spacing", c, ({16'h0, r} + 32'h1) * adc_ready_pkg::MOD_DIV * 2);
  endtask : t_rate
  // Second reset with upstream high; one frame only so the FIFO never stalls
  task automatic t_upstream;
    int bad, c;
    @(negedge mclk);
    rst = 1'b1;
    ready_chain_in_n = 1'b1;
    repeat (4) @(negedge mclk);
    rst = 1'b0;
    bad = 0;
    repeat (200) begin @(posedge mclk); #1; if (ready_out_n !== 1'b1) bad++; end
    check("ready held high", bad, 0);
    @(negedge mclk);
    ready_chain_in_n = 1'b0;
    wait_ready(c);
    check("ready after upstream low", c < 500, 1'b1);
    drain(1'b0);
  endtask : t_upstream
  task automatic final_report;
    if (failCount == 0 && cmpCount > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : final_report
  initial begin
    repeat (20000) @(posedge mclk);
    failCount++;
    final_report;
  end
  initial begin
    osc_clock_in = 1'b0;
    rst = 1'b1;
    ready_chain_in_n = 1'b0;
    sync_in = 1'b0;
    rateSetting = 16'h0007;
    chDelay = 32'h00000000;
    go = 1'b0;
    slow = 1'b0;
    repeat (4) @(negedge mclk);
    rst = 1'b0;
    @(posedge mclk);
    #1;
    check("ready after reset", ready_out_n, 1'b1);
    wait_ready(n);
    check("ready on result", n < 500, 1'b1);
    drain(1'b0);
    t_delay;
    t_sync;
    t_rate(16'h0004);
    t_rate(16'h0007);
    t_upstream;
    final_report;
  end
endmodule : test_adc_ready_chain_sync
